// *** scm_pkg.sv ***
// Function
// - Halt with both halt enables low enters sleep; processor and sub clock stop.
// - In sleep the low-speed oscillator keeps running while the watchdog is enabled.
// - Halt with only the low enable set: processor off, low oscillator runs.
// - Halt with both enables set: processor off, both oscillators run.
// - Halt with only the high enable set: processor and low oscillator off.
// - Select codes 000 to 110 divide the high clock by 1 to 64; 111 picks sub.
// - The high halt enable keeps the high oscillator running during halt when one.
// - The low halt enable keeps the low oscillator running during halt when one.
// - Enabling the high oscillator clears its stable flag, then sets it once stable.
// - The stable flag is read-only: zero while unstable, one when stable.
// - The high oscillator enable is read-write, enables when one, resets to one.
// - Oscillator control bits 7 to 2 always read as zero.
// - Speed changes only via the select field; low-power entry only on halt.
// - A switch to slow operation completes only once the low oscillator is stable.
// - The sub clock is derived from the low-speed internal oscillator.
`default_nettype none
package scm_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_SYSCTL = 8'h00;
  localparam logic [7:0] OFS_INTERNAL_HIGH_SPEED_OSC   = 8'h04;
  localparam logic [7:0] OFS_INTSTS = 8'h08;
  localparam logic [7:0] OFS_INTMSK = 8'h0c;
  localparam logic [7:0] OFS_MODE   = 8'h10;

  // ****************************************
  // Fields
  // ****************************************
  localparam int SEL_LSB   = 5;
  localparam int HS_BIT    = 1;
  localparam int LS_BIT    = 0;
  localparam int STBL_BIT  = 1;
  localparam int HEN_BIT   = 0;
  localparam int NUM_EVT   = 4;
  localparam int EVT_STBL  = 0;
  localparam int EVT_HALT  = 1;
  localparam int EVT_WAKE  = 2;
  localparam int EVT_SWCH  = 3;

  localparam logic [2:0] SEL_SUB    = 3'h7;
  localparam logic [2:0] SEL_RST    = 3'h0;
  localparam logic       HEN_RST    = 1'h1;
  localparam logic [5:0] DIV_ONES   = 6'h3f;
  localparam logic [2:0] SEL_DIV_MAX = 3'h6;
  localparam int MODE_LSB  = 0;
  localparam int ASEL_LSB  = 4;

  // Operating state, Gray coded along run, idle and sleep.
  typedef enum logic [2:0] {
    ST_RUN   = 3'h0,
    ST_HALT_LOW_OSC_ONLY = 3'h1,
    ST_HALT_BOTH_OSC_ON = 3'h3,
    ST_HALT_HIGH_OSC_ONLY = 3'h2,
    ST_SLEEP = 3'h6
  } scm_mode_t;

endpackage
`default_nettype wire

// *** scm_clock_mode.sv ***
`timescale 1ns/10ps
`default_nettype none
module scm_clock_mode #(
  parameter int SETTLE_CYCLES = 256
) (
  // Clock and reset
  input  wire  logic        clk,
  input  wire  logic        rst_n,
  // APB slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output var   logic [31:0] prdata,
  output var   logic        pready,
  output var   logic        pslverr,
  // Processor and system events
  input  wire  logic        haltReq,
  input  wire  logic        wakeReq,
  input  wire  logic        wdtEnable,
  // Low-speed oscillator
  input  wire  logic        lowOscTick,
  input  wire  logic        lowOscStable,
  // Clock enables, oscillator controls and interrupt
  output var   logic        sysClkEn,
  output var   logic        cpuClkEn,
  output var   logic        subClkEn,
  output var   logic        hsOscOn,
  output var   logic        lsOscOn,
  output var   logic        irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0]                    rdata;
    logic                           ready;
    logic                           slverr;
    logic [2:0]                     clkSel;
    logic                           hsHaltEn;
    logic                           lsHaltEn;
    logic                           internal_high_speed_osc_enable;
    logic                           hircStable;
    logic [15:0]                    stabCnt;
    logic [2:0]                     activeSel;
    logic [5:0]                     divCnt;
    logic                           swArmed;
    scm_pkg::scm_mode_t             mode;
    logic [scm_pkg::NUM_EVT-1:0]    intSts;
    logic [scm_pkg::NUM_EVT-1:0]    intMsk;
    logic                           irq;
    logic                           sysClkEn;
    logic                           cpuClkEn;
    logic                           subClkEn;
    logic                           hsOscOn;
    logic                           lsOscOn;
  } scm_state_t;

  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);

  logic [1:0]  rstSync;
  logic        rstSyncN;
  scm_state_t  st;
  scm_state_t  next_st;
  logic        wrEn;
  logic        access;
  logic        hsTick;
  logic        subTick;
  logic        curTick;
  logic        tgtTick;
  logic        tgtReady;
  logic        running;
  logic [31:0] rdMux;
  logic [scm_pkg::NUM_EVT-1:0] evt;

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'h1};
    end
  end
  assign rstSyncN = rstSync[1];

  // ****************************************
  // Clock sources
  // ****************************************
  // High clock runs only when its oscillator is on and settled.
  always_comb begin
    hsTick  = 1'h0;
    subTick = lowOscTick & lowOscStable;
    if (st.hsOscOn && st.hircStable) begin
      hsTick = (st.divCnt & (scm_pkg::DIV_ONES >> (scm_pkg::SEL_DIV_MAX - st.activeSel)))
               == (scm_pkg::DIV_ONES >> (scm_pkg::SEL_DIV_MAX - st.activeSel));
    end
    curTick  = (st.activeSel == scm_pkg::SEL_SUB) ? subTick : hsTick;
    tgtReady = (st.clkSel == scm_pkg::SEL_SUB) ? lowOscStable
               : (st.hsOscOn && st.hircStable);
    tgtTick  = (st.clkSel == scm_pkg::SEL_SUB) ? subTick : 1'h1;
  end

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb begin
    rdMux = 32'h0;
    case (paddr)
      scm_pkg::OFS_SYSCTL: begin
        rdMux[scm_pkg::SEL_LSB +: 3] = st.clkSel;
        rdMux[scm_pkg::HS_BIT]       = st.hsHaltEn;
        rdMux[scm_pkg::LS_BIT]       = st.lsHaltEn;
      end
      scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC: begin
        rdMux[scm_pkg::STBL_BIT] = st.hircStable;
        rdMux[scm_pkg::HEN_BIT]  = st.internal_high_speed_osc_enable;
      end
      scm_pkg::OFS_INTSTS: begin
        rdMux[scm_pkg::NUM_EVT-1:0] = st.intSts;
      end
      scm_pkg::OFS_INTMSK: begin
        rdMux[scm_pkg::NUM_EVT-1:0] = st.intMsk;
      end
      scm_pkg::OFS_MODE: begin
        rdMux[scm_pkg::MODE_LSB +: 3] = st.mode;
        rdMux[scm_pkg::ASEL_LSB +: 3] = st.activeSel;
      end
      default: begin
        rdMux = 32'h0;
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    evt     = '0;
    access  = psel & penable;
    wrEn    = access & st.ready & pwrite;
    running = (st.mode == scm_pkg::ST_RUN);

    // One wait state on every access; answer is registered.
    next_st.ready  = access & ~st.ready;
    next_st.rdata  = 32'h0;
    next_st.slverr = 1'h0;
    if (access && !st.ready) begin
      next_st.rdata  = pwrite ? 32'h0 : rdMux;
      next_st.slverr = (paddr != scm_pkg::OFS_SYSCTL) && (paddr != scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC)
                       && (paddr != scm_pkg::OFS_INTSTS) && (paddr != scm_pkg::OFS_INTMSK)
                       && (paddr != scm_pkg::OFS_MODE);
    end

    if (wrEn) begin
      case (paddr)
        scm_pkg::OFS_SYSCTL: begin
          next_st.clkSel   = pwdata[scm_pkg::SEL_LSB +: 3];
          next_st.hsHaltEn = pwdata[scm_pkg::HS_BIT];
          next_st.lsHaltEn = pwdata[scm_pkg::LS_BIT];
        end
        scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC: begin
          next_st.internal_high_speed_osc_enable = pwdata[scm_pkg::HEN_BIT];
          if (pwdata[scm_pkg::HEN_BIT] && !st.internal_high_speed_osc_enable) begin
            next_st.hircStable = 1'h0;
            next_st.stabCnt    = 16'h0;
          end
        end
        scm_pkg::OFS_INTMSK: begin
          next_st.intMsk = pwdata[scm_pkg::NUM_EVT-1:0];
        end
        default: begin
          next_st.clkSel = next_st.clkSel;
        end
      endcase
    end

    // Halt entry picks the mode from the two halt enables; wake returns to run.
    case (st.mode)
      scm_pkg::ST_RUN: begin
        if (haltReq) begin
          evt[scm_pkg::EVT_HALT] = 1'h1;
          case ({st.hsHaltEn, st.lsHaltEn})
            2'b00:   next_st.mode = scm_pkg::ST_SLEEP;
            2'b01:   next_st.mode = scm_pkg::ST_HALT_LOW_OSC_ONLY;
            2'b11:   next_st.mode = scm_pkg::ST_HALT_BOTH_OSC_ON;
            default: next_st.mode = scm_pkg::ST_HALT_HIGH_OSC_ONLY;
          endcase
        end
      end
      scm_pkg::ST_HALT_LOW_OSC_ONLY, scm_pkg::ST_HALT_BOTH_OSC_ON, scm_pkg::ST_HALT_HIGH_OSC_ONLY, scm_pkg::ST_SLEEP: begin
        if (wakeReq) begin
          next_st.mode           = scm_pkg::ST_RUN;
          evt[scm_pkg::EVT_WAKE] = 1'h1;
        end
      end
      default: begin
        next_st.mode = scm_pkg::ST_RUN;
      end
    endcase

    // Oscillator power follows the mode and the halt enables.
    case (next_st.mode)
      scm_pkg::ST_RUN: begin
        next_st.hsOscOn = next_st.internal_high_speed_osc_enable;
        next_st.lsOscOn = 1'h1;
      end
      scm_pkg::ST_SLEEP: begin
        next_st.hsOscOn = 1'h0;
        next_st.lsOscOn = wdtEnable;
      end
      default: begin
        next_st.hsOscOn = st.hsHaltEn & next_st.internal_high_speed_osc_enable;
        next_st.lsOscOn = st.lsHaltEn;
      end
    endcase

    // Settling counter restarts whenever the oscillator is off.
    if (!st.hsOscOn) begin
      next_st.hircStable = 1'h0;
      next_st.stabCnt    = 16'h0;
    end else if (!st.hircStable && next_st.internal_high_speed_osc_enable) begin
      if (st.stabCnt == SETTLE_LAST) begin
        next_st.hircStable       = 1'h1;
        evt[scm_pkg::EVT_STBL]   = 1'h1;
      end else begin
        next_st.stabCnt = st.stabCnt + 16'h1;
      end
    end
    next_st.divCnt = st.divCnt + 6'h1;

    // A source change has two steps: the old source ends its period (or is dead) and the
    // system clock pauses, then the live new source starts a fresh period at its own tick.
    if ((st.clkSel == st.activeSel) || !tgtReady) begin
      next_st.swArmed = 1'h0;
    end else if (st.swArmed) begin
      if (tgtTick) begin
        next_st.activeSel      = st.clkSel;
        next_st.divCnt         = 6'h0;
        next_st.swArmed        = 1'h0;
        evt[scm_pkg::EVT_SWCH] = 1'h1;
      end
    end else if (curTick || ((st.activeSel == scm_pkg::SEL_SUB) ? !lowOscStable
                             : !(st.hsOscOn && st.hircStable))) begin
      next_st.swArmed = 1'h1;
    end

    next_st.sysClkEn = curTick & running & ~st.swArmed;
    next_st.cpuClkEn = curTick & running & ~st.swArmed;
    next_st.subClkEn = subTick & (running || (st.mode == scm_pkg::ST_HALT_LOW_OSC_ONLY)
                                  || (st.mode == scm_pkg::ST_HALT_BOTH_OSC_ON));

    // Sticky status: a new event wins over a write-one clear.
    for (int i = 0; i < scm_pkg::NUM_EVT; i++) begin
      if (evt[i]) begin
        next_st.intSts[i] = 1'h1;
      end else if (wrEn && (paddr == scm_pkg::OFS_INTSTS) && pwdata[i]) begin
        next_st.intSts[i] = 1'h0;
      end
    end
    next_st.irq = |(next_st.intSts & next_st.intMsk);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st            <= '0;
      st.clkSel     <= scm_pkg::SEL_RST;
      st.activeSel  <= scm_pkg::SEL_RST;
      st.internal_high_speed_osc_enable     <= scm_pkg::HEN_RST;
      st.mode       <= scm_pkg::ST_RUN;
      st.hsOscOn    <= 1'h1;
      st.lsOscOn    <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata   = st.rdata;
  assign pready   = st.ready;
  assign pslverr  = st.slverr;
  assign sysClkEn = st.sysClkEn;
  assign cpuClkEn = st.cpuClkEn;
  assign subClkEn = st.subClkEn;
  assign hsOscOn  = st.hsOscOn;
  assign lsOscOn  = st.lsOscOn;
  assign irq      = st.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncN);

  a_sleep_entry: assert property (running && haltReq && !st.hsHaltEn && !st.lsHaltEn
    |=> st.mode == scm_pkg::ST_SLEEP && !hsOscOn ##1 !cpuClkEn && !subClkEn)
    else $error("sleep not entered");
  a_sleep_internal_low_speed_osc: assert property (st.mode == scm_pkg::ST_SLEEP && $past(st.mode) == scm_pkg::ST_SLEEP
    |-> lsOscOn == $past(wdtEnable))
    else $error("low oscillator wrong in sleep");
  a_halt_low_osc_only_entry: assert property (running && haltReq && !st.hsHaltEn && st.lsHaltEn
    |=> st.mode == scm_pkg::ST_HALT_LOW_OSC_ONLY && lsOscOn && !hsOscOn)
    else $error("halt_low_osc_only not entered");
  a_halt_both_osc_on_entry: assert property (running && haltReq && st.hsHaltEn && st.lsHaltEn
    |=> st.mode == scm_pkg::ST_HALT_BOTH_OSC_ON && lsOscOn && hsOscOn == st.internal_high_speed_osc_enable)
    else $error("halt_both_osc_on not entered");
  a_halt_high_osc_only_entry: assert property (running && haltReq && st.hsHaltEn && !st.lsHaltEn
    |=> st.mode == scm_pkg::ST_HALT_HIGH_OSC_ONLY && !lsOscOn ##1 !cpuClkEn)
    else $error("halt_high_osc_only not entered");
  a_internal_high_speed_osc_restart: assert property (wrEn && paddr == scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC && pwdata[scm_pkg::HEN_BIT] && !st.internal_high_speed_osc_enable
    |=> !st.hircStable [*2])
    else $error("stable flag not cleared on enable");
  a_internal_high_speed_osc_reserved: assert property (access && !st.ready && !pwrite && paddr == scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC
    |=> pready && prdata[31:2] == 30'h0 && prdata[1] == $past(st.hircStable))
    else $error("oscillator register reads wrong");
  a_sub_stable: assert property ($changed(st.activeSel) && st.activeSel == scm_pkg::SEL_SUB
    |-> $past(lowOscStable))
    else $error("switched to unstable sub clock");
  a_switch_clean: assert property ($changed(st.activeSel) && $past(st.activeSel) == scm_pkg::SEL_SUB
    |-> $past(subTick, 2) || !$past(lowOscStable, 2))
    else $error("sub clock period cut short");
  a_halt_only: assert property (running && !haltReq |=> st.mode == scm_pkg::ST_RUN)
    else $error("low power entered without halt");
  a_switch_gap: assert property ($changed(st.activeSel) |-> !sysClkEn)
    else $error("system clock pulse at source change");
  a_sysctl_reserved: assert property (access && !st.ready && !pwrite && paddr == scm_pkg::OFS_SYSCTL
    |=> pready && prdata[4:2] == 3'h0 && prdata[31:8] == 24'h0)
    else $error("clock control reserved bits not zero");
  a_sub_source: assert property (subClkEn |-> $past(lowOscTick) && $past(lowOscStable))
    else $error("sub clock not from low oscillator");
  a_hen_write: assert property (wrEn && paddr == scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC
    |=> st.internal_high_speed_osc_enable == $past(pwdata[scm_pkg::HEN_BIT]))
    else $error("oscillator enable not written");
  a_stable_rise: assert property (!st.hircStable && !(st.hsOscOn && st.stabCnt == SETTLE_LAST)
    |=> !st.hircStable)
    else $error("stable flag set before settling");
  a_halt_refused: assert property (!running && haltReq && !wakeReq
    |=> st.mode == $past(st.mode))
    else $error("halt while halted changed mode");
  a_cpu_halted: assert property (!running |=> !cpuClkEn)
    else $error("processor clock while halted");
  a_sleep_hosc: assert property (st.mode == scm_pkg::ST_SLEEP && $past(st.mode) == scm_pkg::ST_SLEEP
    |-> !hsOscOn)
    else $error("high oscillator on in sleep");
  a_sub_gated: assert property (st.mode == scm_pkg::ST_SLEEP || st.mode == scm_pkg::ST_HALT_HIGH_OSC_ONLY
    |=> !subClkEn)
    else $error("sub clock runs in sleep or halt_high_osc_only");
  a_sub_live: assert property ((st.mode == scm_pkg::ST_HALT_LOW_OSC_ONLY || st.mode == scm_pkg::ST_HALT_BOTH_OSC_ON) && subTick
    |=> subClkEn)
    else $error("sub clock stopped in halt_low_osc_only or halt_both_osc_on");
  a_stable_drop: assert property (!st.hsOscOn |=> !st.hircStable)
    else $error("stable flag kept with oscillator off");

  c_sleep_wake: cover property (st.mode == scm_pkg::ST_SLEEP ##[1:20] running);
  c_halt_both_osc_on: cover property (st.mode == scm_pkg::ST_HALT_BOTH_OSC_ON);
  c_to_sub: cover property ($changed(st.activeSel) && st.activeSel == scm_pkg::SEL_SUB);
  c_halt_high_osc_only: cover property (st.mode == scm_pkg::ST_HALT_HIGH_OSC_ONLY ##[1:60] running);
  c_armed: cover property ($rose(st.swArmed));

endmodule
`default_nettype wire

// *** scm_testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ****************************************
  // Stimulus, clock and counters
  // ****************************************
  localparam int SETTLE = 20;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} scm_tb_row_t;
  typedef struct packed {logic h; logic l; logic w; logic [2:0] m; logic ls;} scm_tb_halt_t;
  logic        clk          = 1'b0;
  logic        rst_n        = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [7:0]  paddr        = 8'h00;
  logic [31:0] pwdata       = 32'h0;
  logic        haltReq      = 1'b0;
  logic        wakeReq      = 1'b0;
  logic        wdtEnable    = 1'b0;
  logic        lowOscTick   = 1'b0;
  logic        lowOscStable = 1'b1;
  logic [31:0] prdata;
  logic        pready, pslverr, sysClkEn, cpuClkEn, subClkEn, hsOscOn, lsOscOn, irq;
  logic [31:0] q;
  logic        err;
  int          badCount = 0, nTests = 0, cyc = 0, sysCnt = 0, cpuCnt = 0, subCnt = 0, c0, s0;
  scm_tb_row_t rows [5] = '{
    '{1'b0, scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC, 32'h0, 32'h1}, '{1'b0, scm_pkg::OFS_SYSCTL, 32'h0, 32'h0},
    '{1'b0, scm_pkg::OFS_MODE, 32'h0, 32'h0}, '{1'b1, scm_pkg::OFS_SYSCTL, 32'h1f, 32'h3},
    '{1'b1, scm_pkg::OFS_SYSCTL, 32'h0, 32'h0}};
  scm_tb_halt_t hc [5] = '{
    '{1'b0, 1'b0, 1'b1, scm_pkg::ST_SLEEP, 1'b1}, '{1'b0, 1'b0, 1'b0, scm_pkg::ST_SLEEP, 1'b0},
    '{1'b0, 1'b1, 1'b0, scm_pkg::ST_HALT_LOW_OSC_ONLY, 1'b1}, '{1'b1, 1'b1, 1'b0, scm_pkg::ST_HALT_BOTH_OSC_ON, 1'b1},
    '{1'b1, 1'b0, 1'b1, scm_pkg::ST_HALT_HIGH_OSC_ONLY, 1'b0}};

  always #2 clk = ~clk;

  scm_clock_mode #(.SETTLE_CYCLES(SETTLE)) dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .haltReq(haltReq),
    .wakeReq(wakeReq), .wdtEnable(wdtEnable), .lowOscTick(lowOscTick), .lowOscStable(lowOscStable),
    .sysClkEn(sysClkEn), .cpuClkEn(cpuClkEn), .subClkEn(subClkEn), .hsOscOn(hsOscOn),
    .lsOscOn(lsOscOn), .irq(irq));

  // The low oscillator ticks once every eight cycles; enables are counted to measure rates.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    lowOscTick <= (cyc % 8 == 7);
    sysCnt <= sysCnt + 32'(sysClkEn === 1'b1);
    cpuCnt <= cpuCnt + 32'(cpuClkEn === 1'b1);
    subCnt <= subCnt + 32'(subClkEn === 1'b1);
    if (cyc == 20000) begin
      badCount++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Called just after a rising edge; returns two edges after the access so outputs have settled.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    chk("waitStates", 32'h2, 32'(k));
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic rate(input logic [31:0] e);
    int s = sysCnt;
    repeat (128) @(posedge clk);
    chk("sysRate", e, 32'(sysCnt - s));
  endtask

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("regRow", rows[i].e, q);
    end
    repeat (SETTLE + 4) @(posedge clk);
    apb(1'b0, scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC, 32'h0);
    chk("hircStable", 32'h3, q);
    apb(1'b1, scm_pkg::OFS_INTSTS, 32'hf);
    apb(1'b1, scm_pkg::OFS_INTMSK, 32'h1);
    apb(1'b1, scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC, 32'hfc);
    apb(1'b0, scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC, 32'h0);
    chk("hircOff", 32'h0, q);
    chk("hsOscOff", 32'h0, 32'(hsOscOn));
    apb(1'b1, scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC, 32'h1);
    apb(1'b0, scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC, 32'h0);
    chk("hircRestart", 32'h1, q);
    chk("irqIdle", 32'h0, 32'(irq));
    repeat (SETTLE + 4) @(posedge clk);
    apb(1'b0, scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC, 32'h0);
    chk("hircSettled", 32'h3, q);
    chk("irqRaised", 32'h1, 32'(irq));
    apb(1'b1, scm_pkg::OFS_INTMSK, 32'h0);
    chk("irqMasked", 32'h0, 32'(irq));
    apb(1'b1, scm_pkg::OFS_INTMSK, 32'h1);
    chk("irqUnmasked", 32'h1, 32'(irq));
    apb(1'b1, scm_pkg::OFS_INTSTS, 32'h1);
    chk("irqCleared", 32'h0, 32'(irq));
    wakeReq <= 1'b1;
    @(posedge clk);
    wakeReq <= 1'b0;
    apb(1'b0, scm_pkg::OFS_MODE, 32'h0);
    chk("runMode", 32'h0, q & 32'h7);
    for (int i = 0; i < 5; i++) begin
      wdtEnable <= hc[i].w;
      apb(1'b1, scm_pkg::OFS_SYSCTL, {30'h0, hc[i].h, hc[i].l});
      haltReq <= 1'b1;
      @(posedge clk);
      haltReq <= 1'b0;
      repeat (4) @(posedge clk);
      c0 = cpuCnt;
      s0 = subCnt;
      apb(1'b0, scm_pkg::OFS_MODE, 32'h0);
      chk("haltMode", {29'h0, hc[i].m}, q & 32'h7);
      chk("hsOscOn", 32'(hc[i].h), 32'(hsOscOn));
      chk("lsOscOn", 32'(hc[i].ls), 32'(lsOscOn));
      repeat (40) @(posedge clk);
      chk("cpuStopped", 32'h0, 32'(cpuCnt - c0));
      chk("subRunning", 32'(hc[i].l), 32'(subCnt != s0));
      wakeReq <= 1'b1;
      @(posedge clk);
      wakeReq <= 1'b0;
      repeat (SETTLE + 40) @(posedge clk);
      c0 = cpuCnt;
      repeat (16) @(posedge clk);
      chk("cpuResumed", 32'h1, 32'(cpuCnt != c0));
    end
    for (int n = 0; n < 7; n++) begin
      apb(1'b1, scm_pkg::OFS_SYSCTL, 32'(n) << 5);
      repeat (150) @(posedge clk);
      rate(32'(128 >> n));
    end
    lowOscStable <= 1'b0;
    apb(1'b1, scm_pkg::OFS_SYSCTL, 32'he0);
    repeat (150) @(posedge clk);
    rate(32'h2);
    lowOscStable <= 1'b1;
    repeat (150) @(posedge clk);
    rate(32'h10);
    apb(1'b0, scm_pkg::OFS_MODE, 32'h0);
    chk("activeSel", 32'h7, (q >> 4) & 32'h7);
    apb(1'b1, scm_pkg::OFS_SYSCTL, 32'h0);
    repeat (150) @(posedge clk);
    rate(32'h80);
    apb(1'b1, scm_pkg::OFS_SYSCTL, 32'he3);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("rstIrq", 32'h0, 32'(irq));
    chk("rstHsOscOn", 32'h1, 32'(hsOscOn));
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, scm_pkg::OFS_SYSCTL, 32'h0);
    chk("rstSysctl", 32'h0, q);
    apb(1'b0, scm_pkg::OFS_INTERNAL_HIGH_SPEED_OSC, 32'h0);
    chk("rstHirc", 32'h1, q);
    apb(1'b1, 8'h14, 32'hff);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmappedData", 32'h0, q);
    chk("unmappedErr", 32'h1, 32'(err));
    conclude();
  end
endmodule
`default_nettype wire
